// ---- src/oag_top.sv ----
// Contract
// - File-register direct mode takes the address straight from the instruction field.
// - Register direct mode uses the working register itself and forms no address.
// - Register indirect mode uses the base pointer unchanged as the address.
// - Post-modified indirect uses the pointer, then steps it by a constant.
// - Pre-modified indirect adds a signed constant first and uses the result.
// - Register-indexed mode adds the base pointer and the offset register.
// - Literal-offset indirect adds the base pointer and an instruction literal.
// - Move and accumulator instructions also accept register-indexed mode.
// - Move source and destination pick modes apart but share one 4-bit offset field.
// - Multiply-accumulate prefetch pointers must be one of the four X/Y pointers.
// - X pointer reads go to the X address generator.
// - Y pointer reads go to the Y address generator.
// - Multiply-accumulate indexing exists only for the high X and high Y pointers.
// - Multiply-accumulate allows plain indirect, post-modify by plus or minus 2, 4 or 6, and indexed.
// - Each instruction class is allowed only its own subset of modes.
module oag_top
  import oag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic req,
  input wire logic [1:0] cls,
  input wire logic [2:0] src_mode,
  input wire logic [OAG_RW-1:0] src_reg,
  input wire logic [2:0] dst_mode,
  input wire logic [OAG_RW-1:0] dst_reg,
  input wire logic [OAG_RW-1:0] offset_sel,
  input wire logic [OAG_DW-1:0] lit,
  input wire logic [OAG_DW-1:0] file_addr,
  input wire logic [2:0] mac_step,
  input wire logic [OAG_DW-1:0] wreg_wr_data,
  input wire logic [OAG_RW-1:0] wreg_wr_sel,
  input wire logic wreg_wr_en,
  output logic src_valid,
  output logic [OAG_DW-1:0] src_addr,
  output logic src_is_mem,
  output logic [1:0] src_agu,
  output logic dst_valid,
  output logic [OAG_DW-1:0] dst_addr,
  output logic dst_is_mem,
  output logic illegal
);
  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ------------------------------------------------------------
  // Working registers
  // ------------------------------------------------------------
  logic [OAG_DW-1:0] wreg [OAG_NREG];

  // ------------------------------------------------------------
  // Multiply-accumulate pointer checks and step decode
  // ------------------------------------------------------------
  wire is_mac = (cls == OAG_CLS_MAC);
  wire mac_ptr_ok = (src_reg == OAG_XP_LO) || (src_reg == OAG_XP_HI) ||
                    (src_reg == OAG_YP_LO) || (src_reg == OAG_YP_HI);
  wire mac_is_y = (src_reg == OAG_YP_LO) || (src_reg == OAG_YP_HI);
  wire mac_idx = (mac_step == OAG_MAC_IDX);
  wire mac_idx_ok = (src_reg == OAG_XP_HI) || (src_reg == OAG_YP_HI);
  wire mac_step_ok = (mac_step != OAG_MAC_IDX) || mac_idx_ok;
  logic [OAG_DW-1:0] mac_delta;
  always_comb begin
    case (mac_step)
      OAG_MAC_P2: mac_delta = OAG_STEP2;
      OAG_MAC_P4: mac_delta = OAG_STEP4;
      OAG_MAC_P6: mac_delta = OAG_STEP6;
      OAG_MAC_M2: mac_delta = -OAG_STEP2;
      OAG_MAC_M4: mac_delta = -OAG_STEP4;
      OAG_MAC_M6: mac_delta = -OAG_STEP6;
      default: mac_delta = '0;
    endcase
  end
  wire [2:0] mac_mode = mac_idx ? OAG_M_IDX :
                        (mac_step == OAG_MAC_NONE) ? OAG_M_IND : OAG_M_POST;

  // ------------------------------------------------------------
  // Per-class mode filter
  // ------------------------------------------------------------
  function automatic logic mode_ok(input logic [1:0] c, input logic [2:0] m);
    logic ok;
    ok = 1'b0;
    case (c)
      OAG_CLS_ORD: ok = (m <= OAG_M_PRE) || (m == OAG_M_LIT);
      OAG_CLS_MOVE,
      OAG_CLS_ACC: ok = (m != OAG_M_FILE) && (m <= OAG_M_LIT);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  wire src_ok = is_mac ? (mac_ptr_ok && mac_step_ok) : mode_ok(cls, src_mode);
  wire dst_ok = is_mac || mode_ok(cls, dst_mode);
  wire dst_used = (cls == OAG_CLS_MOVE);
  wire bad = !src_ok || (dst_used && !dst_ok);

  // ------------------------------------------------------------
  // Address calculators, shared offset field
  // ------------------------------------------------------------
  oag_ea_if s_if ();
  oag_ea_if d_if ();
  assign s_if.mode = is_mac ? mac_mode : src_mode;
  assign s_if.base = wreg[src_reg];
  assign s_if.offs = wreg[offset_sel];
  assign s_if.lit = is_mac ? mac_delta : lit;
  assign s_if.file_addr = file_addr;
  assign d_if.mode = dst_mode;
  assign d_if.base = wreg[dst_reg];
  assign d_if.offs = wreg[offset_sel];
  assign d_if.lit = lit;
  assign d_if.file_addr = file_addr;
  oag_ea_calc u_src (.e(s_if));
  oag_ea_calc u_dst (.e(d_if));

  wire take = req && !bad;
  wire [1:0] next_agu = !is_mac ? OAG_AGU_MAIN : (mac_is_y ? OAG_AGU_Y : OAG_AGU_X);

  // ------------------------------------------------------------
  // Pointer write-back and register file
  // ------------------------------------------------------------
  wire s_upd = take && s_if.upd_en;
  wire d_upd = take && dst_used && d_if.upd_en;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < OAG_NREG; i++) wreg[i] <= '0;
    end else begin
      if (wreg_wr_en) wreg[wreg_wr_sel] <= wreg_wr_data;
      if (s_upd) wreg[src_reg] <= s_if.upd_val;
      if (d_upd) wreg[dst_reg] <= d_if.upd_val;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_valid <= 1'b0;
      src_addr <= '0;
      src_is_mem <= 1'b0;
      src_agu <= OAG_AGU_MAIN;
      dst_valid <= 1'b0;
      dst_addr <= '0;
      dst_is_mem <= 1'b0;
      illegal <= 1'b0;
    end else begin
      src_valid <= take;
      src_addr <= take ? s_if.eff : '0;
      src_is_mem <= take && s_if.uses_mem;
      src_agu <= next_agu;
      dst_valid <= take && dst_used;
      dst_addr <= (take && dst_used) ? d_if.eff : '0;
      dst_is_mem <= take && dst_used && d_if.uses_mem;
      illegal <= req && bad;
    end
  end
endmodule

// ---- src/oag_pkg.sv ----
package oag_pkg;
  localparam int OAG_DW = 16;
  localparam int OAG_RW = 4;
  localparam int OAG_NREG = 16;
  // Instruction class
  typedef enum logic [1:0] {
    OAG_CLS_ORD = 2'h0,
    OAG_CLS_MOVE = 2'h1,
    OAG_CLS_ACC = 2'h2,
    OAG_CLS_MAC = 2'h3
  } oag_cls_e;
  // Operand addressing mode
  typedef enum logic [2:0] {
    OAG_M_FILE = 3'h0,
    OAG_M_REG = 3'h1,
    OAG_M_IND = 3'h2,
    OAG_M_POST = 3'h3,
    OAG_M_PRE = 3'h4,
    OAG_M_IDX = 3'h5,
    OAG_M_LIT = 3'h6
  } oag_mode_e;
  // Multiply-accumulate prefetch pointers
  localparam logic [3:0] OAG_XP_LO = 4'h8;
  localparam logic [3:0] OAG_XP_HI = 4'h9;
  localparam logic [3:0] OAG_YP_LO = 4'ha;
  localparam logic [3:0] OAG_YP_HI = 4'hb;
  // Multiply-accumulate post-modify step codes
  localparam logic [2:0] OAG_MAC_NONE = 3'h0;
  localparam logic [2:0] OAG_MAC_P2 = 3'h1;
  localparam logic [2:0] OAG_MAC_P4 = 3'h2;
  localparam logic [2:0] OAG_MAC_P6 = 3'h3;
  localparam logic [2:0] OAG_MAC_M2 = 3'h4;
  localparam logic [2:0] OAG_MAC_M4 = 3'h5;
  localparam logic [2:0] OAG_MAC_M6 = 3'h6;
  localparam logic [2:0] OAG_MAC_IDX = 3'h7;
  localparam logic [15:0] OAG_STEP2 = 16'h0002;
  localparam logic [15:0] OAG_STEP4 = 16'h0004;
  localparam logic [15:0] OAG_STEP6 = 16'h0006;
  // Address generator targets
  localparam logic [1:0] OAG_AGU_MAIN = 2'h0;
  localparam logic [1:0] OAG_AGU_X = 2'h1;
  localparam logic [1:0] OAG_AGU_Y = 2'h2;
endpackage

// ---- src/oag_ea_if.sv ----
interface oag_ea_if;
  import oag_pkg::*;
  logic [2:0] mode;
  logic [OAG_DW-1:0] base;
  logic [OAG_DW-1:0] offs;
  logic [OAG_DW-1:0] lit;
  logic [OAG_DW-1:0] file_addr;
  logic [OAG_DW-1:0] eff;
  logic [OAG_DW-1:0] upd_val;
  logic uses_mem;
  logic upd_en;
  modport calc (input mode, base, offs, lit, file_addr, output eff, upd_val, uses_mem, upd_en);
  modport user (output mode, base, offs, lit, file_addr, input eff, upd_val, uses_mem, upd_en);
endinterface

// ---- src/oag_ea_calc.sv ----
module oag_ea_calc
  import oag_pkg::*;
(
  oag_ea_if.calc e
);
  wire [OAG_DW-1:0] sum_lit = e.base + e.lit;
  wire [OAG_DW-1:0] sum_off = e.base + e.offs;
  always_comb begin
    e.eff = '0;
    e.upd_val = e.base;
    e.uses_mem = 1'b1;
    e.upd_en = 1'b0;
    case (e.mode)
      OAG_M_FILE: e.eff = e.file_addr;
      OAG_M_REG: e.uses_mem = 1'b0;
      OAG_M_IND: e.eff = e.base;
      OAG_M_POST: begin
        e.eff = e.base;
        e.upd_val = sum_lit;
        e.upd_en = 1'b1;
      end
      OAG_M_PRE: begin
        e.eff = sum_lit;
        e.upd_val = sum_lit;
        e.upd_en = 1'b1;
      end
      OAG_M_IDX: e.eff = sum_off;
      OAG_M_LIT: e.eff = sum_lit;
      default: e.uses_mem = 1'b0;
    endcase
  end
endmodule

// ---- dv/oag_chk.sv ----
module oag_chk
  import oag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic req,
  input wire logic [1:0] cls,
  input wire logic [2:0] src_mode,
  input wire logic [OAG_RW-1:0] src_reg,
  input wire logic [2:0] mac_step,
  input wire logic [OAG_DW-1:0] file_addr,
  input wire logic src_valid,
  input wire logic [OAG_DW-1:0] src_addr,
  input wire logic src_is_mem,
  input wire logic [1:0] src_agu,
  input wire logic dst_valid,
  input wire logic illegal
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  wire mac = req && cls == OAG_CLS_MAC;
  wire xp = src_reg == OAG_XP_LO || src_reg == OAG_XP_HI;
  wire yp = src_reg == OAG_YP_LO || src_reg == OAG_YP_HI;
  wire lo = src_reg == OAG_XP_LO || src_reg == OAG_YP_LO;
  // ----
  // Checks
  // ----
  one_answer_a: assert property (req |=> src_valid != illegal)
    else $error("answer count");
  quiet_idle_a: assert property (!req |=> !src_valid && !dst_valid && !illegal)
    else $error("answer without request");
  file_addr_a: assert property (req && cls == OAG_CLS_ORD && src_mode == OAG_M_FILE
    |=> src_valid && src_addr == $past(file_addr)) else $error("file address");
  reg_direct_a: assert property (req && !cls[0] && !cls[1] && src_mode == OAG_M_REG
    |=> src_valid && !src_is_mem) else $error("register direct");
  ord_idx_a: assert property (req && cls == OAG_CLS_ORD && src_mode == OAG_M_IDX |=> illegal)
    else $error("ordinary indexed");
  move_idx_a: assert property (req && cls inside {OAG_CLS_MOVE, OAG_CLS_ACC} && src_mode == OAG_M_IDX
    |=> src_valid) else $error("move indexed");
  mac_ptr_a: assert property (mac && !xp && !yp |=> illegal && !src_valid)
    else $error("pointer set");
  mac_x_a: assert property (mac && xp && mac_step != OAG_MAC_IDX |=> src_agu == OAG_AGU_X)
    else $error("x route");
  mac_y_a: assert property (mac && yp && mac_step != OAG_MAC_IDX |=> src_agu == OAG_AGU_Y)
    else $error("y route");
  mac_idx_lo_a: assert property (mac && lo && mac_step == OAG_MAC_IDX |=> illegal)
    else $error("low pointer indexed");
  illegal_quiet_a: assert property (illegal |-> !src_valid && !dst_valid && src_addr == 16'h0000)
    else $error("illegal with address");
  dst_move_a: assert property (req && cls != OAG_CLS_MOVE |=> !dst_valid)
    else $error("destination outside move");
  cover property (mac && xp ##1 src_valid);
  cover property (req && cls == OAG_CLS_MOVE ##1 dst_valid);
  cover property (illegal);
endmodule

// ---- dv/oag_top_bench.sv ----
module oag_top_bench;
  import oag_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rstn = 0, req = 0, wreg_wr_en = 0;
  logic src_valid, src_is_mem, dst_valid, dst_is_mem, illegal;
  logic [1:0] cls = 0, src_agu;
  logic [2:0] src_mode = 0, mac_step = 0, dst_mode = 3'h2;
  logic [3:0] src_reg = 0, dst_reg = 4'h5, offset_sel = 4'h3, wreg_wr_sel = 0;
  logic [15:0] lit = 0, file_addr = 16'h1234, wreg_wr_data = 0, src_addr, dst_addr, p;
  int err_count = 0, num_checks = 0, cyc = 0;
  oag_top i_dut (.*);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  // ----
  // Tasks
  // ----
  task automatic print_verdict;
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] r, input logic [15:0] d);
    @(posedge clk_sys);
    wreg_wr_en <= 1'b1;
    wreg_wr_sel <= r;
    wreg_wr_data <= d;
    @(posedge clk_sys);
    wreg_wr_en <= 1'b0;
  endtask
  task automatic op(input logic [1:0] c, input logic [2:0] m, input logic [3:0] r,
                    input logic [15:0] l, input logic [2:0] s);
    @(posedge clk_sys);
    req <= 1'b1;
    cls <= c;
    src_mode <= m;
    src_reg <= r;
    lit <= l;
    mac_step <= s;
    @(posedge clk_sys);
    req <= 1'b0;
    #1;
  endtask
  task automatic t_modes;
    wr(4'h2, 16'h0200);
    wr(4'h3, 16'h0010);
    wr(4'h5, 16'h0400);
    op(OAG_CLS_ORD, OAG_M_FILE, 4'h2, 16'h0000, 3'h0);
    chk(src_addr, 16'h1234);
    op(OAG_CLS_ORD, OAG_M_REG, 4'h2, 16'h0000, 3'h0);
    chk({14'h0, src_valid, src_is_mem}, 16'h0002);
    op(OAG_CLS_ORD, OAG_M_POST, 4'h2, 16'hfffe, 3'h0);
    chk(src_addr, 16'h0200);
    op(OAG_CLS_ORD, OAG_M_IND, 4'h2, 16'h0000, 3'h0);
    chk(src_addr, 16'h01fe);
    op(OAG_CLS_ORD, OAG_M_PRE, 4'h2, 16'h0004, 3'h0);
    chk(src_addr, 16'h0202);
    op(OAG_CLS_ORD, OAG_M_LIT, 4'h2, 16'h0030, 3'h0);
    chk(src_addr, 16'h0232);
    op(OAG_CLS_ORD, OAG_M_IDX, 4'h2, 16'h0000, 3'h0);
    chk({15'h0, illegal}, 16'h0001);
    op(OAG_CLS_MOVE, OAG_M_IDX, 4'h2, 16'h0000, 3'h0);
    chk(src_addr, 16'h0212);
    chk(dst_addr, 16'h0400);
    chk({14'h0, dst_valid, dst_is_mem}, 16'h0003);
    op(OAG_CLS_ACC, OAG_M_IDX, 4'h2, 16'h0000, 3'h0);
    chk(src_addr, 16'h0212);
  endtask
  task automatic t_mac;
    wr(4'h8, 16'h1000);
    wr(4'h9, 16'h1100);
    wr(4'ha, 16'h2000);
    wr(4'hb, 16'h2100);
    p = 16'h2000;
    for (int i = 1; i < 8; i++) begin
      op(OAG_CLS_MAC, 3'h0, OAG_YP_LO, 16'h0000, (i == 7) ? OAG_MAC_NONE : i[2:0]);
      chk(src_addr, p);
      chk({14'h0, src_agu}, {14'h0, OAG_AGU_Y});
      p = (i < 4) ? p + 16'(2 * i) : p - 16'(2 * (i - 3));
    end
    op(OAG_CLS_MAC, 3'h0, OAG_XP_LO, 16'h0000, OAG_MAC_P4);
    chk({14'h0, src_agu}, {14'h0, OAG_AGU_X});
    chk(src_addr, 16'h1000);
    op(OAG_CLS_MAC, 3'h0, OAG_XP_HI, 16'h0000, OAG_MAC_IDX);
    chk({14'h0, src_agu}, {14'h0, OAG_AGU_X});
    chk(src_addr, 16'h1110);
    op(OAG_CLS_MAC, 3'h0, OAG_YP_HI, 16'h0000, OAG_MAC_IDX);
    chk({14'h0, src_agu}, {14'h0, OAG_AGU_Y});
    chk(src_addr, 16'h2110);
    op(OAG_CLS_MAC, 3'h0, OAG_XP_LO, 16'h0000, OAG_MAC_IDX);
    chk({15'h0, illegal}, 16'h0001);
    op(OAG_CLS_MAC, 3'h0, 4'h3, 16'h0000, OAG_MAC_P2);
    chk({14'h0, src_valid, illegal}, 16'h0001);
    chk(src_addr, 16'h0000);
    op(OAG_CLS_MAC, 3'h0, OAG_XP_LO, 16'h0000, OAG_MAC_NONE);
    chk(src_addr, 16'h1004);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_modes();
    t_mac();
    print_verdict();
  end
endmodule
bind oag_top oag_chk u_chk (.*);
